// file: dv/qcm_host.sv
// system host model: apb master that polls the congestion registers
`timescale 1ns/1ps
module qcm_host (
    input wire logic clock,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    int timeouts = 0; // transfers that never saw pready
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer; request held until pready is sampled high or 64 access cycles pass, host polling path
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        output logic [31:0] rdata, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        // bounded wait: a hung slave must not stall the run
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            timeouts++;
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// file: dv/qcm_properties.sv
// checker of apb and event timing at the monitor's ports
`timescale 1ns/1ps
module qcm_properties
    import qcm_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic eg_pkt_done,
    input wire logic irq,
    input wire logic port_write_req
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    logic [INT_W-1:0] mask_sh; // mask as last written over apb
    logic mapped; // address hits a register
    assign mapped = paddr inside {OFF_EG_THR, OFF_EG_OTC, OFF_EG_STS, OFF_REORD, OFF_IN_THR,
                                  OFF_IN_OTC, OFF_IN_STS, OFF_INT_STS, OFF_INT_MSK};
    // shadow the mask, so irq can be judged without seeing inside
    always_ff @(posedge clock) begin
        if (srst) begin
            mask_sh <= '0;
        end else if (clk_en && psel && penable && pready && pwrite && paddr == OFF_INT_MSK) begin
            mask_sh <= pwdata[INT_W-1:0];
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_access;
        psel && penable && clk_en;
    endsequence
    a_pready_after_setup: assert property (s_setup ##1 s_access |-> pready)
        else $error("pready missing in access phase");
    a_pready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    a_reset_quiet: assert property ($fell(srst) |-> !pready && !irq && !port_write_req && prdata == 32'h0)
        else $error("outputs active after reset");
    a_prdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    a_irq_needs_mask: assert property (irq |-> $past(mask_sh) != '0)
        else $error("irq with all sources masked");
    a_irq_after_alarm: assert property (port_write_req && mask_sh[INT_EG_CONG] |=> irq)
        else $error("irq missing after congestion alarm");
    a_pwr_cause: assert property (port_write_req |-> $past(eg_pkt_done, 2))
        else $error("port write without a packet arrival");
    a_pwr_single: assert property (port_write_req |=> !port_write_req)
        else $error("port write request longer than a pulse");
    a_stall_freeze: assert property (!clk_en |=> $stable(prdata) && $stable(pready) && $stable(irq))
        else $error("outputs moved while the clock enable was low");
endmodule

// file: dv/queue_congestion_monitor_test.sv
// self-checking testbench of the queue congestion monitor
`timescale 1ns/1ps
module queue_congestion_monitor_test import qcm_pkg::*;;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1; // low only in the stall scenario
    logic eg_pkt_done = 1'b0;
    logic in_pkt_done = 1'b0;
    logic eg_bias_tick = 1'b0;
    logic in_bias_tick = 1'b0;
    logic fabric_reorder = 1'b0;
    logic [7:0] qcount = 8'h05; // queued packet count shown with each arrival
    logic psel, penable, pwrite, pready, pslverr, irq, port_write_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic rd_e;
    logic [7:0] base;
    int mismatches = 0;
    int compares = 0;
    int pwr_seen = 0;
    initial begin
        forever #12.5 clock = ~clock;
    end
    qcm_monitor #(.QCNT_W(8)) dut_u (.clock(clock), .srst(srst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eg_pkt_done(eg_pkt_done), .eg_pkt_count(qcount),
        .in_pkt_done(in_pkt_done), .in_pkt_count(qcount), .eg_bias_tick(eg_bias_tick),
        .in_bias_tick(in_bias_tick), .fabric_reorder(fabric_reorder), .irq(irq),
        .port_write_req(port_write_req));
    qcm_host host_u (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // count notification pulses as they go by
    always @(posedge clock) begin
        if (port_write_req === 1'b1) begin
            pwr_seen++;
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, rd_q, rd_e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, a, 32'h0, rd_q, rd_e);
        check(rd_q, exp);
    endtask
    // n back-to-back pulses: 0 egress, 1 ingress, 2 reorder, 3/4 bias ticks
    task automatic evt(input int kind, input int n);
        repeat (n) begin
            @(posedge clock);
            eg_pkt_done <= (kind == 0);
            in_pkt_done <= (kind == 1);
            fabric_reorder <= (kind == 2);
            eg_bias_tick <= (kind == 3);
            in_bias_tick <= (kind == 4);
        end
        @(posedge clock);
        {eg_pkt_done, in_pkt_done, fabric_reorder, eg_bias_tick, in_bias_tick} <= 5'h00;
        repeat (3) @(posedge clock);
    endtask
    task automatic summarize();
        mismatches += host_u.timeouts;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        // reset values and an unmapped place
        rd(OFF_EG_THR, 32'({RST_TICK, RST_TICK, RST_DEPTH}));
        rd(OFF_IN_THR, 32'({RST_TICK, RST_TICK, RST_DEPTH}));
        rd(OFF_EG_STS, {RST_ALARM, 16'h0000});
        rd(OFF_REORD, {RST_ALARM, 16'h0000});
        rd(OFF_INT_MSK, 32'(RST_MASK));
        rd(8'h1c, 32'h0);
        check(32'(rd_e), 32'h1);
        wr(OFF_INT_MSK, 32'h7);
        // both queues: depth compare, strict alarm, bias tick, clear
        for (int q = 0; q < 2; q++) begin
            base = (q == 0) ? 8'h00 : 8'h10;
            wr(base + OFF_EG_STS, 32'h00020000);
            qcount <= 8'h04;
            evt(q, 1);
            rd(base + OFF_EG_STS, 32'h00020000);
            qcount <= 8'h05;
            evt(q, 2);
            rd(OFF_INT_STS, 32'h0);
            evt(q, 1);
            rd(base + OFF_EG_STS, 32'h00020003);
            check(32'(irq), 32'h1);
            evt(3 + q, 1);
            rd(base + OFF_EG_STS, 32'h00020002);
            rd(OFF_INT_STS, 32'h1 << q);
            rd(OFF_INT_STS, 32'h0);
            wr(OFF_INT_STS, 32'h1 << q);
            rd(base + OFF_EG_STS, 32'h00020000);
        end
        check(32'(pwr_seen), 32'h1);
        check(32'(irq), 32'h0);
        // drain ticks empty the level and stop at zero
        wr(OFF_EG_STS, 32'h00ff0000);
        evt(0, 3);
        wr(OFF_EG_THR, 32'h00000304);
        repeat (20) @(posedge clock);
        rd(OFF_EG_STS, 32'h00ff0000);
        // period ticks count only while the level is above zero
        wr(OFF_EG_THR, 32'h00500004);
        repeat (20) @(posedge clock);
        rd(OFF_EG_OTC, 32'h0);
        evt(0, 1);
        repeat (20) @(posedge clock);
        wr(OFF_EG_THR, 32'h00000004);
        wr(OFF_INT_STS, 32'h1);
        // five period ticks fell while the level was one
        rd(OFF_EG_OTC, 32'h5);
        rd(OFF_EG_OTC, 32'h0);
        // reorder events against their alarm
        wr(OFF_REORD, 32'h00020000);
        evt(2, 2);
        rd(OFF_INT_STS, 32'h0);
        evt(2, 1);
        rd(OFF_REORD, 32'h00020003);
        rd(OFF_INT_STS, 32'h4);
        // a low enable freezes the counter even while picks arrive
        clk_en <= 1'b0;
        evt(2, 2);
        clk_en <= 1'b1;
        rd(OFF_REORD, 32'h00020003);
        summarize();
    end
endmodule
bind qcm_monitor qcm_properties chk_u (.clock(clock), .srst(srst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eg_pkt_done(eg_pkt_done), .irq(irq), .port_write_req(port_write_req));

// file: verilog/qcm_monitor.sv
// per-port queue congestion monitor with apb register slave
//
// Overview of operation
// - period tick advances tick counter when level nonzero
// - tick counter totals, cleared only by read
// - full packet in, depth exceeded: level plus one
// - drain tick decrements the congestion level
// - error bias tick also decrements the level
// - write one to status bit clears level
// - level above alarm sets congestion status bit
// - fabric picks non-head packet: reorder count plus one
// - reorder count above alarm sets reorder bit
// - ingress queue gets identical copy of logic
// - both congestion bits live in one status register
// - egress congestion rise may request port-write
`timescale 1ns/1ps
module qcm_monitor
    import qcm_pkg::*;
#(
    parameter int QCNT_W = 8 // width of the queued packet count inputs
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // egress queue events
    input wire logic eg_pkt_done,
    input wire logic [QCNT_W-1:0] eg_pkt_count,
    // ingress queue events
    input wire logic in_pkt_done,
    input wire logic [QCNT_W-1:0] in_pkt_count,
    // error rate bias timer tick, from outside
    input wire logic eg_bias_tick,
    input wire logic in_bias_tick,
    // switching_fabric took a non-head packet from the ingress queue
    input wire logic fabric_reorder,
    // outputs
    output logic irq,
    output logic port_write_req
);

    // ----------------------------------------
    // functions
    // ----------------------------------------

    // address match on a word offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // saturating counter step: one up, up to two down
    function automatic logic [15:0] sat_step(input logic [15:0] v, input logic inc,
                                             input logic [1:0] dec);
        logic [16:0] t;
        // widen by one bit so the carry shows an overflow
        t = {1'b0, v} + {16'h0000, inc};
        if (t[16]) begin
            t = {1'b0, 16'hffff}; // hold at top instead of rolling over
        end
        if (t < {15'h0000, dec}) begin
            return 16'h0000; // never wrap below zero
        end
        return t[15:0] - {14'h0000, dec};
    endfunction

    // ----------------------------------------
    // state, index 0 egress, index 1 ingress
    // ----------------------------------------
    logic [DEPTH_W-1:0] depth_r [2];      // depth threshold
    logic [TICK_W-1:0] drain_r [2];       // drain_tick_count
    logic [TICK_W-1:0] period_r [2];      // congestion_tick_interval
    logic [LEVEL_W-1:0] alarm_r [2];      // congestion_alarm_level
    logic [LEVEL_W-1:0] level_r [2];      // congestion_level_counter
    logic [31:0] otc_r [2];               // over_threshold_tick_counter
    logic [TICK_W-1:0] ptmr_r [2];        // period timer
    logic [TICK_W-1:0] dtmr_r [2];        // drain timer
    logic [LEVEL_W-1:0] rcnt_r;           // reorder_event_counter
    logic [LEVEL_W-1:0] ralarm_r;         // reorder_alarm_level
    logic [INT_W-1:0] int_sts_r;          // sticky status
    logic [INT_W-1:0] int_msk_r;          // mask, one enables
    logic [INT_W-1:0] cond_prev_r;        // last alarm conditions
    // apb response flops, so the bus outputs leave registers
    logic [31:0] prdata_r; // read word captured at setup
    logic pready_r; // high in the access cycle
    logic pslverr_r; // unmapped address flag
    // interrupt and notification outputs
    logic irq_r; // level interrupt
    logic pw_req_r; // port-write request pulse

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic setup_ph;  // first cycle of a transfer
    logic wr_acc;    // write completes this edge
    logic rd_acc;    // read completes this edge
    logic mapped;    // address belongs to a register
    // queue inputs gathered into arrays
    logic pkt_done [2];     // per-queue packet arrival
    logic [QCNT_W-1:0] pkt_count [2];
    logic bias_tick [2];
    logic [INT_W-1:0] cond;         // alarm conditions now
    logic ptick [2];                // period timer expiry
    logic dtick [2];                // drain timer expiry
    logic lvl_clr [2];              // software clear of level
    // per-queue register offsets, so one loop decodes both
    logic [7:0] thr_off [2];
    logic [7:0] otc_off [2];
    logic [7:0] sts_off [2];

    // phase decode; all of it is gated by the clock enable
    assign setup_ph = clk_en & psel & ~penable;
    // the access phase always sees pready high, so every transfer is two cycles
    assign wr_acc = clk_en & psel & penable & pready_r & pwrite;
    assign rd_acc = clk_en & psel & penable & pready_r & ~pwrite;
    // any address outside the map answers with pslverr
    assign mapped = hit(paddr, OFF_EG_THR) | hit(paddr, OFF_EG_OTC) | hit(paddr, OFF_EG_STS) |
                    hit(paddr, OFF_REORD) | hit(paddr, OFF_IN_THR) | hit(paddr, OFF_IN_OTC) |
                    hit(paddr, OFF_IN_STS) | hit(paddr, OFF_INT_STS) | hit(paddr, OFF_INT_MSK);

    // gather the two queues into arrays so one loop serves both
    // egress sits at index 0, ingress at index 1
    assign pkt_done[0] = eg_pkt_done;
    assign pkt_done[1] = in_pkt_done;
    assign pkt_count[0] = eg_pkt_count;
    assign pkt_count[1] = in_pkt_count;
    assign bias_tick[0] = eg_bias_tick;
    assign bias_tick[1] = in_bias_tick;
    // fixed offsets of each queue's own registers
    assign thr_off[0] = OFF_EG_THR;
    assign thr_off[1] = OFF_IN_THR;
    assign otc_off[0] = OFF_EG_OTC;
    assign otc_off[1] = OFF_IN_OTC;
    assign sts_off[0] = OFF_EG_STS;
    assign sts_off[1] = OFF_IN_STS;

    // ----------------------------------------
    // tick strobes and clears
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // an interval of zero parks the timer
            ptick[i] = (period_r[i] != RST_TICK) && (ptmr_r[i] == period_r[i] - 12'h001);
            dtick[i] = (drain_r[i] != RST_TICK) && (dtmr_r[i] == drain_r[i] - 12'h001);
            // a one written to the queue's status bit empties its level
            lvl_clr[i] = wr_acc && hit(paddr, OFF_INT_STS) && pwdata[i];
        end
    end

    // alarm conditions, strictly greater than the alarm level
    // a level equal to the alarm does not raise the bit
    assign cond[INT_EG_CONG] = level_r[0] > alarm_r[0];
    assign cond[INT_IN_CONG] = level_r[1] > alarm_r[1];
    // the reorder alarm watches the single ingress counter
    assign cond[INT_REORD] = rcnt_r > ralarm_r;

    // ----------------------------------------
    // tick timers
    // ----------------------------------------
    // one period and one drain timer per queue
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                ptmr_r[i] <= RST_TICK;
                dtmr_r[i] <= RST_TICK;
            end
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                // free-running counters that restart on expiry
                if (ptick[i] || period_r[i] == RST_TICK) begin
                    ptmr_r[i] <= RST_TICK;
                end else begin
                    ptmr_r[i] <= ptmr_r[i] + 12'h001;
                end
                // the drain timer restarts the same way
                if (dtick[i] || drain_r[i] == RST_TICK) begin
                    dtmr_r[i] <= RST_TICK;
                end else begin
                    dtmr_r[i] <= dtmr_r[i] + 12'h001;
                end
            end
        end
    end

    // ----------------------------------------
    // congestion level counters
    // ----------------------------------------
    // one counter per queue; both drains may hit in one cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                // levels start empty
                level_r[i] <= 16'h0000;
            end
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                // a clear empties the old count, but events of this cycle still count
                level_r[i] <= sat_step(lvl_clr[i] ? 16'h0000 : level_r[i],
                                       pkt_done[i] && ({{(32-QCNT_W){1'b0}}, pkt_count[i]} >
                                                       {24'h000000, depth_r[i]}),
                                       {1'b0, dtick[i]} + {1'b0, bias_tick[i]});
            end
        end
    end

    // ----------------------------------------
    // over-threshold tick counters
    // ----------------------------------------
    // running totals; only a read of the register empties them
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                // totals start at zero
                otc_r[i] <= 32'h00000000;
            end
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (rd_acc && hit(paddr, otc_off[i])) begin
                    // read clears, yet a tick in the same cycle is kept
                    otc_r[i] <= {31'h00000000, ptick[i] && level_r[i] != 16'h0000};
                end else if (ptick[i] && level_r[i] != 16'h0000 && otc_r[i] != 32'hffffffff) begin
                    // hold at the top rather than wrap
                    otc_r[i] <= otc_r[i] + 32'h00000001;
                end
            end
        end
    end

    // ----------------------------------------
    // reorder event counter
    // ----------------------------------------
    // counts non-head picks; it never decrements
    always_ff @(posedge clock) begin
        if (srst) begin
            rcnt_r <= 16'h0000;
        end else if (clk_en) begin
            if (wr_acc && hit(paddr, OFF_REORD)) begin
                // a write restarts the count; a pick in that cycle still counts
                rcnt_r <= {15'h0000, fabric_reorder};
            end else begin
                // saturate at the top instead of rolling over
                rcnt_r <= sat_step(rcnt_r, fabric_reorder, 2'h0);
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // software-written fields; writes to read-only halves are dropped
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                depth_r[i] <= RST_DEPTH;
                drain_r[i] <= RST_TICK;
                period_r[i] <= RST_TICK;
                alarm_r[i] <= RST_ALARM;
            end
            // reorder alarm shares the default of the level alarms
            ralarm_r <= RST_ALARM;
            int_msk_r <= RST_MASK;
        end else if (wr_acc) begin
            for (int i = 0; i < 2; i++) begin
                if (hit(paddr, thr_off[i])) begin
                    depth_r[i] <= pwdata[DEPTH_LSB +: DEPTH_W];
                    drain_r[i] <= pwdata[DRAIN_LSB +: TICK_W];
                    period_r[i] <= pwdata[PERIOD_LSB +: TICK_W];
                end
                if (hit(paddr, sts_off[i])) begin
                    // the level half is read-only
                    alarm_r[i] <= pwdata[ALARM_LSB +: LEVEL_W];
                end
            end
            if (hit(paddr, OFF_REORD)) begin
                ralarm_r <= pwdata[ALARM_LSB +: LEVEL_W];
            end
            // mask bits enable the matching status bits onto irq
            if (hit(paddr, OFF_INT_MSK)) begin
                int_msk_r <= pwdata[INT_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // interrupt status, mask and output
    // ----------------------------------------
    // sticky status set on a rising alarm condition
    always_ff @(posedge clock) begin
        if (srst) begin
            int_sts_r <= 3'h0;
            cond_prev_r <= 3'h0;
            irq_r <= 1'b0;
        end else if (clk_en) begin
            // remember the conditions to find their rising edge
            cond_prev_r <= cond;
            // set on a rising condition; set wins over a read clear in the same cycle
            if (rd_acc && hit(paddr, OFF_INT_STS)) begin
                int_sts_r <= cond & ~cond_prev_r;
            end else if (wr_acc && hit(paddr, OFF_INT_STS)) begin
                // a write of ones clears only the congestion bits
                int_sts_r <= (int_sts_r & ~{1'b0, pwdata[1:0]}) | (cond & ~cond_prev_r);
            end else begin
                int_sts_r <= int_sts_r | (cond & ~cond_prev_r);
            end
            // level output, one cycle behind the status
            irq_r <= |(int_sts_r & int_msk_r);
        end
    end

    // ----------------------------------------
    // port-write request
    // ----------------------------------------
    // one pulse per rise of the egress congestion condition; the packet builder sits outside
    always_ff @(posedge clock) begin
        if (srst) begin
            pw_req_r <= 1'b0;
        end else if (clk_en) begin
            pw_req_r <= cond[INT_EG_CONG] & ~cond_prev_r[INT_EG_CONG];
        end
    end

    // ----------------------------------------
    // apb response
    // ----------------------------------------
    // data is captured in the setup cycle so prdata leaves a flop; the cost is a
    // fixed wait of none beyond the access phase, with values as of setup
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            // no wait states: ready always follows setup
            pready_r <= setup_ph;
            pslverr_r <= setup_ph & ~mapped; // unmapped address answers with an error
            if (setup_ph && !pwrite) begin
                // the host follows the trend by polling these fields
                case (paddr)
                    OFF_EG_THR: prdata_r <= {period_r[0], drain_r[0], depth_r[0]};
                    OFF_EG_OTC: prdata_r <= otc_r[0];
                    OFF_EG_STS: prdata_r <= {alarm_r[0], level_r[0]};
                    OFF_REORD: prdata_r <= {ralarm_r, rcnt_r};
                    OFF_IN_THR: prdata_r <= {period_r[1], drain_r[1], depth_r[1]};
                    OFF_IN_OTC: prdata_r <= otc_r[1];
                    OFF_IN_STS: prdata_r <= {alarm_r[1], level_r[1]};
                    OFF_INT_STS: prdata_r <= {29'h00000000, int_sts_r};
                    OFF_INT_MSK: prdata_r <= {29'h00000000, int_msk_r};
                    // holes in the map read as zero
                    default: prdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // every output is a plain copy of its flop
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign port_write_req = pw_req_r;

endmodule

// file: verilog/qcm_pkg.sv
// package of register map, field layout and reset values for the queue congestion monitor
package qcm_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_EG_THR = 8'h00;  // egress_queue_depth_threshold
    localparam logic [7:0] OFF_EG_OTC = 8'h04;  // egress_over_threshold_tick_count
    localparam logic [7:0] OFF_EG_STS = 8'h08;  // egress_congestion_status
    localparam logic [7:0] OFF_REORD = 8'h0c;   // ingress_reorder_counter
    localparam logic [7:0] OFF_IN_THR = 8'h10;  // ingress_queue_depth_threshold
    localparam logic [7:0] OFF_IN_OTC = 8'h14;  // ingress_over_threshold_tick_count
    localparam logic [7:0] OFF_IN_STS = 8'h18;  // ingress_congestion_status
    localparam logic [7:0] OFF_INT_STS = 8'h20; // interrupt status
    localparam logic [7:0] OFF_INT_MSK = 8'h24; // interrupt mask
    // ----------------------------------------
    // field positions and widths
    // ----------------------------------------
    localparam int DEPTH_LSB = 0;   // depth threshold in threshold register
    localparam int DEPTH_W = 8;
    localparam int DRAIN_LSB = 8;   // drain_tick_count
    localparam int TICK_W = 12;
    localparam int PERIOD_LSB = 20; // congestion_tick_interval
    localparam int LEVEL_LSB = 0;   // counter field in status / reorder register
    localparam int LEVEL_W = 16;
    localparam int ALARM_LSB = 16;  // alarm level field
    localparam int INT_W = 3;
    localparam int INT_EG_CONG = 0; // egress_congestion_interrupt
    localparam int INT_IN_CONG = 1; // ingress congestion interrupt
    localparam int INT_REORD = 2;   // ingress_reorder_interrupt
    // ----------------------------------------
    // values after reset
    // ----------------------------------------
    localparam logic [7:0] RST_DEPTH = 8'h04;
    localparam logic [11:0] RST_TICK = 12'h000;  // zero keeps a timer stopped
    localparam logic [15:0] RST_ALARM = 16'h0008;
    localparam logic [2:0] RST_MASK = 3'h0;
endpackage
